// *** core/bdm_pkg.sv ***
/*
 Constants for the banked data memory addressing block.
 Assumes a single core clock and the CPU datapath as the only user.
*/
package bdm_pkg;
  localparam int ADDR_W = 12;
  localparam int OFFS_W = 8;
  localparam int BANK_W = 4;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 4096;
  localparam int NUM_BANKS = 16;
  localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
  localparam logic [BANK_W-1:0] SFR_BANK = 4'hF;
  localparam logic [BANK_W-1:0] LOW_BANK = 4'h0;
  localparam logic [OFFS_W-1:0] ACCESS_SPLIT = 8'h60;
  localparam logic [OFFS_W-1:0] PCL_OFFS = 8'hF9;
  localparam logic [OFFS_W-1:0] BANKPTR_OFFS = 8'hE0;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [NUM_BANKS-1:0] BANKS_IMPL = 16'hFFFF;
  typedef enum logic [2:0] {
    BDM_OP_BANKED = 3'b001,
    BDM_OP_ACCESS = 3'b010,
    BDM_OP_FULL = 3'b100
  } bdm_mode_t;
endpackage : bdm_pkg

// *** core/bdm_core.sv ***
/*
 Banked data memory with bank pointer, fast-access mapping and full-address move.
 Assumes the CPU datapath presents one request per cycle, synchronous to i_sys_clk.
*/
// Behaviour
// - Every byte has a 12-bit address; 4096 bytes addressable.
// - Sixteen 256-byte banks, all implemented.
// - Reads of locations without storage return zero.
// - Reach a byte by full address or offset plus bank pointer.
// - Bank pointer gives upper 4 bits, operand gives lower 8 bits.
// - Bank pointer upper four bits read zero and ignore writes.
// - Load-bank-literal writes its immediate into the bank pointer.
// - Fast-access bank reaches special registers and low bank 0 without pointer.
// - Writes to unimplemented banks dropped; reads return zero.
// - Unimplemented-bank accesses still report status update as successful.
// - Full-address move uses 12-bit source and target, ignores bank pointer.
// - Other accesses use operand with bank pointer or fast-access mapping.
// - Bank 0Fh offset F9h is program counter low; writes load it.
`timescale 1ns/10ps
`default_nettype none
module bdm_core (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic [2:0] i_mode, // bdm_mode_t access mode
  input wire logic i_rd, // Read strobe
  input wire logic i_wr, // Write strobe
  input wire logic [7:0] i_offs, // Instruction low-order operand
  input wire logic [11:0] i_src_addr, // Full-address move source
  input wire logic [11:0] i_dst_addr, // Full-address move target
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_load_bank, // Load-bank-literal strobe
  input wire logic [7:0] i_bank_lit, // Load-bank-literal immediate
  output logic [7:0] o_rdata, // Registered read data
  output logic o_rvalid, // Read data valid pulse
  output logic o_status_upd, // Status flags may update pulse
  output logic [7:0] o_bank_pointer, // Bank pointer readback
  output logic o_pcl_wr, // Program counter low write pulse
  output logic [7:0] o_pcl_data // Program counter low value
);
  ////////////////////////////////////////////////////////////////////////
  logic [bdm_pkg::BANK_W-1:0] bank_reg, bank_next;
  logic [bdm_pkg::DATA_W-1:0] mem_reg [bdm_pkg::MEM_DEPTH];
  logic [bdm_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next, stat_reg, stat_next, pclw_reg, pclw_next;
  logic [bdm_pkg::DATA_W-1:0] pcl_reg, pcl_next;
  logic [bdm_pkg::ADDR_W-1:0] rd_addr, wr_addr, ptr_addr;
  logic wr_hit, wr_bank, wr_pcl;
  localparam int BANK_MSB = bdm_pkg::ADDR_W - 1;
  localparam int BANK_LSB = bdm_pkg::OFFS_W;
  localparam int PAD_W = bdm_pkg::DATA_W - bdm_pkg::BANK_W;
  ////////////////////////////////////////////////////////////////////////
  // Address formation
  always_comb begin
    ptr_addr = {bank_reg, i_offs};
    case (i_mode)
      bdm_pkg::BDM_OP_FULL: begin
        rd_addr = i_src_addr;
        wr_addr = i_dst_addr;
      end
      bdm_pkg::BDM_OP_ACCESS: begin
        // Split point decides bank 0 or special register bank
        if (i_offs < bdm_pkg::ACCESS_SPLIT) begin
          rd_addr = {bdm_pkg::LOW_BANK, i_offs};
        end else begin
          rd_addr = {bdm_pkg::SFR_BANK, i_offs};
        end
        wr_addr = rd_addr;
      end
      default: begin
        rd_addr = ptr_addr;
        wr_addr = ptr_addr;
      end
    endcase
    wr_bank = (wr_addr == {bdm_pkg::SFR_BANK, bdm_pkg::BANKPTR_OFFS});
    wr_pcl = (wr_addr == {bdm_pkg::SFR_BANK, bdm_pkg::PCL_OFFS});
    // Unimplemented banks drop the write
    wr_hit = i_wr && bdm_pkg::BANKS_IMPL[wr_addr[BANK_MSB:BANK_LSB]];
  end
  ////////////////////////////////////////////////////////////////////////
  // Bank pointer, read path, program counter low
  always_comb begin
    bank_next = bank_reg;
    // Literal load beats a same-cycle pointer write
    if (i_load_bank) begin
      bank_next = i_bank_lit[bdm_pkg::BANK_W-1:0];
    end else if (wr_hit && wr_bank) begin
      bank_next = i_wdata[bdm_pkg::BANK_W-1:0];
    end
    // Zero when no read was taken, so idle cycles never show stale data
    rdata_next = bdm_pkg::ZERO_BYTE;
    if (i_rd) begin
      if (!bdm_pkg::BANKS_IMPL[rd_addr[BANK_MSB:BANK_LSB]]) begin
        rdata_next = bdm_pkg::ZERO_BYTE;
      end else if (rd_addr == {bdm_pkg::SFR_BANK, bdm_pkg::BANKPTR_OFFS}) begin
        rdata_next = {{PAD_W{1'b0}}, bank_reg};
      end else begin
        rdata_next = mem_reg[rd_addr];
      end
    end
    rvalid_next = i_rd;
    // Status pulse fires even when the target bank drops the access
    stat_next = i_rd || i_wr;
    // Program counter low keeps a RAM copy too; reads see the RAM
    pclw_next = wr_hit && wr_pcl;
    pcl_next = pclw_next ? i_wdata : pcl_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bank_reg <= bdm_pkg::BANK_RESET;
      rdata_reg <= bdm_pkg::ZERO_BYTE;
      rvalid_reg <= 1'b0;
      stat_reg <= 1'b0;
      pclw_reg <= 1'b0;
      pcl_reg <= bdm_pkg::ZERO_BYTE;
    end else begin
      bank_reg <= bank_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      stat_reg <= stat_next;
      pclw_reg <= pclw_next;
      pcl_reg <= pcl_next;
    end
  end
  // Storage is not reset: RAM contents are undefined at power-up
  always_ff @(posedge i_sys_clk) begin
    if (wr_hit && !wr_bank) begin
      mem_reg[wr_addr] <= i_wdata;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_status_upd = stat_reg;
  assign o_bank_pointer = {{PAD_W{1'b0}}, bank_reg};
  assign o_pcl_wr = pclw_reg;
  assign o_pcl_data = pcl_reg;
  ////////////////////////////////////////////////////////////////////////
  // Bank pointer checks
  sequence s_ptr_write;
    wr_hit && wr_bank && !i_load_bank;
  endsequence
  sequence s_ptr_quiet;
    !i_load_bank && !(wr_hit && wr_bank);
  endsequence
  a_bank_upper_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_bank_pointer[7:4] == 4'h0)
    else $error("bank pointer upper bits set");
  a_bank_literal: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_load_bank
    |=> o_bank_pointer[3:0] == $past(i_bank_lit[3:0]))
    else $error("bank literal not loaded");
  a_bank_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_ptr_write
    |=> o_bank_pointer[3:0] == $past(i_wdata[3:0]))
    else $error("bank pointer write lost");
  a_bank_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_ptr_quiet |=> $stable(o_bank_pointer))
    else $error("bank pointer changed unasked");
  a_bank_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_rd && rd_addr == {bdm_pkg::SFR_BANK, bdm_pkg::BANKPTR_OFFS})
    |=> o_rdata[7:4] == 4'h0)
    else $error("bank pointer readback upper bits set");

  // Address formation checks
  a_banked_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode == bdm_pkg::BDM_OP_BANKED |-> rd_addr == {bank_reg, i_offs})
    else $error("banked address wrong");
  a_access_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == bdm_pkg::BDM_OP_ACCESS && i_offs < bdm_pkg::ACCESS_SPLIT)
    |-> rd_addr == {bdm_pkg::LOW_BANK, i_offs})
    else $error("access low not bank 0");
  a_access_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == bdm_pkg::BDM_OP_ACCESS && i_offs >= bdm_pkg::ACCESS_SPLIT)
    |-> rd_addr == {bdm_pkg::SFR_BANK, i_offs})
    else $error("access high not bank 15");
  a_access_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode == bdm_pkg::BDM_OP_ACCESS |-> wr_addr == rd_addr)
    else $error("access write address differs");
  a_full_src: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode == bdm_pkg::BDM_OP_FULL |-> rd_addr == i_src_addr)
    else $error("full move source wrong");
  a_full_dst: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode == bdm_pkg::BDM_OP_FULL |-> wr_addr == i_dst_addr)
    else $error("full move target wrong");

  // Response pulse checks
  sequence s_any_req;
    i_rd || i_wr;
  endsequence
  a_status_upd: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_any_req |=> o_status_upd)
    else $error("status update missing");
  a_status_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !(i_rd || i_wr) |=> !o_status_upd)
    else $error("status update without access");
  a_read_valid: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rd |=> o_rvalid)
    else $error("read valid missing");
  a_idle_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == 8'h00 && !o_rvalid)
    else $error("idle read not zero");

  // Program counter low checks
  sequence s_full_write;
    i_wr && i_mode == bdm_pkg::BDM_OP_FULL && !i_load_bank;
  endsequence
  a_pcl_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_wr && i_mode == bdm_pkg::BDM_OP_BANKED
      && bank_reg == bdm_pkg::SFR_BANK && i_offs == bdm_pkg::PCL_OFFS)
    |=> o_pcl_wr && o_pcl_data == $past(i_wdata))
    else $error("pcl write lost");
  a_full_ignores_bank: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_full_write ##0 (i_dst_addr == {4'hF, 8'hF9}) |=> o_pcl_wr)
    else $error("full move used bank pointer");
  a_pcl_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_wr |=> !o_pcl_wr)
    else $error("pcl write without write");
  a_pcl_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_pcl_wr |-> $stable(o_pcl_data))
    else $error("pcl value changed unasked");
endmodule : bdm_core
`default_nettype wire

// *** test/bdm_cpu_model.sv ***
/* CPU datapath stand-in issuing one-cycle requests to the memory block.
 Assumes tasks are called by the bench only after reset is released. */
`timescale 1ns/10ps
`default_nettype none
module bdm_cpu_model (
  input wire logic i_sys_clk, // Core clock
  output logic [2:0] o_mode, // Access mode
  output logic o_rd, // Read strobe
  output logic o_wr, // Write strobe
  output logic [7:0] o_offs, // Operand offset
  output logic [11:0] o_addr, // Full-address move address
  output logic [7:0] o_wdata, // Write data
  output logic o_load, // Bank load strobe
  output logic [7:0] o_lit // Bank literal
);
  initial begin
    {o_mode, o_rd, o_wr, o_offs, o_addr, o_wdata, o_load, o_lit} = '0;
  end
  // One idle edge first, so a strobe never drops and rises in one time step
  task automatic acc(input logic [2:0] m, input logic r, input logic [7:0] o,
                     input logic [11:0] a, input logic [7:0] wd);
    @(negedge i_sys_clk);
    {o_mode, o_rd, o_wr, o_offs, o_addr, o_wdata} = {m, r, !r, o, a, wd};
    @(negedge i_sys_clk);
    {o_rd, o_wr} = 2'b00;
  endtask : acc
  task automatic ld(input logic [7:0] v);
    @(negedge i_sys_clk);
    {o_load, o_lit} = {1'b1, v};
    @(negedge i_sys_clk);
    o_load = 1'b0;
  endtask : ld
endmodule : bdm_cpu_model
`default_nettype wire

// *** test/tb_top.sv ***
/* Self-checking bench for the banked data memory block.
 Assumes the CPU model drives all requests at falling edges. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [2:0] BK = bdm_pkg::BDM_OP_BANKED;
  localparam logic [2:0] FA = bdm_pkg::BDM_OP_ACCESS;
  localparam logic [2:0] FU = bdm_pkg::BDM_OP_FULL;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_rd, i_wr, i_load_bank, o_rvalid, o_status_upd, o_pcl_wr;
  logic [2:0] i_mode;
  logic [7:0] i_offs, i_wdata, i_bank_lit, o_rdata, o_bank_pointer, o_pcl_data, d;
  logic [11:0] a;
  int err_total = 0, total_checks = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  bdm_cpu_model cpu (.i_sys_clk, .o_mode(i_mode), .o_rd(i_rd), .o_wr(i_wr), .o_offs(i_offs),
    .o_addr(a), .o_wdata(i_wdata), .o_load(i_load_bank), .o_lit(i_bank_lit));
  bdm_core DUT (.i_sys_clk, .i_rst_n, .i_mode, .i_rd, .i_wr, .i_offs, .i_src_addr(a),
    .i_dst_addr(a), .i_wdata, .i_load_bank, .i_bank_lit, .o_rdata, .o_rvalid, .o_status_upd,
    .o_bank_pointer, .o_pcl_wr, .o_pcl_data);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic go(input logic [2:0] m, input logic r, input logic [7:0] o,
                    input logic [11:0] ad, input logic [7:0] wd);
    cpu.acc(m, r, o, ad, wd);
    d = o_rdata;
    chk({7'h0, o_status_upd}, 8'h01);
    chk({7'h0, o_rvalid}, {7'h0, r});
    if (!r) chk(d, 8'h00);
  endtask : go
  task automatic t_bank_reg;
    chk(o_bank_pointer, 8'h00);
    cpu.ld(8'hFA);
    chk(o_bank_pointer, 8'h0A);
    cpu.ld(8'h0F);
    go(BK, 0, 8'hE0, 12'h000, 8'hF3);
    chk(o_bank_pointer, 8'h03);
    go(FU, 1, 8'h00, 12'hFE0, 8'h00);
    chk(d, 8'h03);
  endtask : t_bank_reg
  task automatic t_all_banks;
    for (int b = 0; b < 16; b++) go(FU, 0, 8'h00, {4'(b), 8'h3C}, 8'h80 | 8'(b));
    for (int b = 0; b < 16; b++) begin
      cpu.ld(8'(b));
      go(BK, 1, 8'h3C, 12'hFFF, 8'h00);
      chk(d, 8'h80 | 8'(b));
    end
    cpu.ld(8'h02);
    go(FU, 1, 8'h00, 12'h73C, 8'h00);
    chk(d, 8'h87);
    go(FU, 0, 8'h00, 12'hFFF, 8'hE7);
    go(FU, 1, 8'h00, 12'hFFF, 8'h00);
    chk(d, 8'hE7);
  endtask : t_all_banks
  task automatic t_fast;
    go(FU, 0, 8'h00, 12'h05F, 8'h5A);
    go(FU, 0, 8'h00, 12'hF60, 8'hA6);
    cpu.ld(8'h07);
    go(FA, 1, 8'h5F, 12'h000, 8'h00);
    chk(d, 8'h5A);
    go(FA, 1, 8'h60, 12'h000, 8'h00);
    chk(d, 8'hA6);
  endtask : t_fast
  task automatic t_pcl;
    cpu.ld(8'h0F);
    go(BK, 0, 8'hF9, 12'h000, 8'hC3);
    chk({7'h0, o_pcl_wr}, 8'h01);
    chk(o_pcl_data, 8'hC3);
    cpu.ld(8'h01);
    go(BK, 0, 8'hF9, 12'h000, 8'h77);
    chk({7'h0, o_pcl_wr}, 8'h00);
    chk(o_pcl_data, 8'hC3);
    go(FU, 0, 8'h00, 12'hFF9, 8'h5C);
    chk({7'h0, o_pcl_wr}, 8'h01);
    chk(o_pcl_data, 8'h5C);
  endtask : t_pcl
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    t_bank_reg();
    t_all_banks();
    t_fast();
    t_pcl();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
